/* dvsc_pkg.sv */
// dvsc_pkg: constants, layouts and types of the dac volume soft-step control
package dvsc_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_VOL_L = 8'h00;
  localparam logic [7:0] IDX_VOL_R = 8'h01;
  localparam logic [7:0] IDX_MASTER = 8'h02;
  localparam logic [7:0] IDX_DAC_CFG = 8'h03;
  localparam logic [7:0] IDX_PWR = 8'h04;
  localparam logic [7:0] IDX_STATUS = 8'h05;
  localparam logic [7:0] IDX_IN_LVL = 8'h06;
  localparam logic [7:0] IDX_ADC_CFG = 8'h07;
  localparam logic [7:0] IDX_OUT_LVL = 8'h08;
  localparam logic [7:0] IDX_CM = 8'h09;
  localparam logic [7:0] IDX_ROUTE = 8'h0a;
  localparam logic [7:0] IDX_BIAS = 8'h6d;
  // volume field: [6:0] half-dB step count, [7] mute
  localparam int VOL_MUTE = 7;
  localparam logic [7:0] GAIN_MUTE = 8'h80; // applied code that means muted
  // dac and adc config bits
  localparam int CFG_SS_OFF = 0;
  localparam int CFG_HALF = 1;
  localparam int CFG_DEEMPH = 2;
  localparam int CFG_FX = 3;
  // power bits
  localparam int PWR_DAC = 0;
  localparam int PWR_ANA_L = 1;
  localparam int PWR_ANA_R = 2;
  localparam int PWR_LINE_L = 3;
  localparam int PWR_LINE_R = 4;
  // status bits
  localparam int ST_DONE = 0;
  localparam int ST_PD = 1;
  localparam int ST_APP_L = 8;
  localparam int ST_APP_R = 16;
  // field layouts
  localparam int NUM_IN = 6;
  localparam int BIAS_LSB = 6;
  localparam int ROUTE_MIX = 10;
  localparam int ROUTE_DIRECT = 11;
  localparam logic [3:0] IN_LVL_MAX = 4'h8; // -12 dB in 1.5 dB steps
  localparam logic [3:0] OUT_LVL_MAX = 4'h9; // +9 dB in 1 dB steps
  // reset values
  localparam logic [7:0] RST_VOL = 8'h00;
  localparam logic [3:0] RST_CFG = 4'h0;
  localparam logic [4:0] RST_PWR = 5'h00;
  localparam logic [1:0] RST_BIAS = 2'h0; // lowest current
  // applied gain of one channel
  typedef struct packed {
    logic mute;
    logic [6:0] atten;
  } dvsc_gain_type;
  // analog settings handed to the mixed-signal side
  typedef struct packed {
    logic [1:0] bias;
    logic [1:0] cm;
    logic [1:0] ana_pwr;
    logic dac_mixer_route;
    logic dac_direct_line_route;
  } dvsc_ana_type;
  // power and effects sequencer
  typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_FX_MUTE, ST_DOWN} dvsc_state_type;
endpackage : dvsc_pkg

/* dvsc_top.sv */
// dvsc_top: dac digital volume, soft-step sequencing and analog control registers
//
// What this block does
// - per-channel attenuation 0 to -63.5 dB, 0.5 dB
// - independent mute bit per dac channel
// - master volume writes both channels together
// - applied gain moves one step per sample
// - config bit halves the soft-step rate
// - read-only flag: soft-step finished, gain matches
// - config bit disables soft-stepping, immediate change
// - power-down flag only after ramp completes
// - effects toggle: soft-mute, switch, soft-unmute
// - power-up starts muted, ramps to target
// - power-down ramps to mute, then removes power
// - two-bit dac bias field, lowest default
// - output common-mode select from four levels
// - left and right dac analog power separate
// - per-input level 0 to -12 dB, 1.5 dB
// - input levels soft-step with adc settings
// - output driver level 0 to +9 dB
// - line drivers power down to high impedance
// - left capture amp source switches, mixable
// - right capture amp mirrored source switches
// - dac routes via mixers or direct line
`timescale 1ns/1ps
`default_nettype none
module dvsc_top
  import dvsc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [9:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // sample strobes from the audio datapath
  input wire logic dac_tick_i,
  input wire logic adc_tick_i,
  // dac volume and effects
  output dvsc_gain_type [1:0] dac_gain_o,
  output logic dac_pwr_o,
  output logic deemph_on_o,
  output logic fx_on_o,
  // capture side
  output logic [4*NUM_IN-1:0] in_lvl_o,
  output logic [4:0] mix_l_o,
  output logic [4:0] mix_r_o,
  // output side
  output logic [7:0] out_lvl_o,
  output logic [1:0] line_oe_o,
  output dvsc_ana_type ana_o
);

  // software-visible settings
  logic [7:0] vol_r [2]; // requested volume per channel
  logic [3:0] dac_cfg_r; // soft-step and effects requests
  logic [3:0] adc_cfg_r; // capture soft-step settings
  logic [4:0] pwr_r; // power requests
  logic [4*NUM_IN-1:0] in_req_r; // requested input levels
  logic [7:0] out_lvl_r; // output driver levels
  logic [1:0] cm_r; // common-mode select
  logic [11:0] route_r; // capture and dac routing
  logic [1:0] bias_r; // dac bias current
  // applied state
  logic [7:0] app_r [2]; // applied attenuation, GAIN_MUTE = muted
  logic [1:0] fx_app_r; // effects mode in use
  logic done_r; // soft-step finished
  dvsc_state_type state_r;
  logic dac_ph_r; // half-rate phase, dac side
  logic adc_ph_r; // half-rate phase, adc side
  // apb answer
  logic rdy_r;
  logic [31:0] rdata_r;
  logic err_r;

  // bus decode
  logic [7:0] idx;
  logic acc;
  logic wr;
  logic hit;
  logic vol_wr;
  logic [31:0] rd_mux;

  assign idx = paddr_i[9:2];
  assign acc = psel_i & penable_i;
  // a write lands in the pready cycle; one that draws pslverr is dropped
  assign wr = acc & rdy_r & pwrite_i & ~err_r;

  // address decode and read mux
  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (idx)
      IDX_VOL_L: rd_mux[7:0] = vol_r[0];
      IDX_VOL_R: rd_mux[7:0] = vol_r[1];
      IDX_MASTER: rd_mux[7:0] = vol_r[0];
      IDX_DAC_CFG: rd_mux[3:0] = dac_cfg_r;
      IDX_PWR: rd_mux[4:0] = pwr_r;
      IDX_STATUS: begin
        rd_mux[ST_DONE] = done_r;
        rd_mux[ST_PD] = (state_r == ST_OFF);
        rd_mux[ST_APP_L +: 8] = app_r[0];
        rd_mux[ST_APP_R +: 8] = app_r[1];
      end
      IDX_IN_LVL: rd_mux[4*NUM_IN-1:0] = in_req_r;
      IDX_ADC_CFG: rd_mux[3:0] = adc_cfg_r;
      IDX_OUT_LVL: rd_mux[7:0] = out_lvl_r;
      IDX_CM: rd_mux[1:0] = cm_r;
      IDX_ROUTE: rd_mux[11:0] = route_r;
      IDX_BIAS: rd_mux[BIAS_LSB +: 2] = bias_r;
      default: hit = 1'b0; // unmapped: slave error
    endcase
  end

  // pready rises in the second access cycle, never the first
  // one wait state so that read data leaves a flip-flop
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rdy_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end else if (acc & ~rdy_r) begin
      rdy_r <= 1'b1;
      rdata_r <= pwrite_i ? 32'h0000_0000 : rd_mux;
      err_r <= ~hit;
    end else begin
      rdy_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end
  end

  assign prdata_o = rdata_r;
  assign pready_o = rdy_r;
  assign pslverr_o = err_r;

  // volume writes; master loads both channels in one access
  assign vol_wr = wr & (idx == IDX_VOL_L | idx == IDX_VOL_R | idx == IDX_MASTER);

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      vol_r[0] <= RST_VOL;
      vol_r[1] <= RST_VOL;
    end else if (wr & idx == IDX_MASTER) begin
      vol_r[0] <= pwdata_i[7:0];
      vol_r[1] <= pwdata_i[7:0];
    end else if (wr & idx == IDX_VOL_L) begin
      vol_r[0] <= pwdata_i[7:0];
    end else if (wr & idx == IDX_VOL_R) begin
      vol_r[1] <= pwdata_i[7:0];
    end
  end

  // remaining control registers
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      dac_cfg_r <= RST_CFG;
      adc_cfg_r <= RST_CFG;
      pwr_r <= RST_PWR;
      in_req_r <= '0;
      out_lvl_r <= 8'h00;
      cm_r <= 2'h0;
      route_r <= 12'h000;
      bias_r <= RST_BIAS;
    end else if (wr) begin
      case (idx)
        IDX_DAC_CFG: dac_cfg_r <= pwdata_i[3:0];
        IDX_ADC_CFG: adc_cfg_r <= pwdata_i[3:0];
        IDX_PWR: pwr_r <= pwdata_i[4:0];
        IDX_IN_LVL: in_req_r <= pwdata_i[4*NUM_IN-1:0];
        IDX_OUT_LVL: out_lvl_r <= pwdata_i[7:0];
        IDX_CM: cm_r <= pwdata_i[1:0];
        IDX_ROUTE: route_r <= pwdata_i[11:0];
        IDX_BIAS: bias_r <= pwdata_i[BIAS_LSB +: 2];
        default: ;
      endcase
    end
  end

  // step helper: one unit toward the target
  // saturates at the target, so a ramp never overshoots
  function automatic logic [7:0] step8(input logic [7:0] cur, input logic [7:0] tgt);
    if (cur < tgt) begin
      return cur + 8'd1;
    end else if (cur > tgt) begin
      return cur - 8'd1;
    end
    return cur;
  endfunction : step8

  // half-rate phases; a step is taken only on the odd sample
  logic dac_step;
  logic adc_step;
  assign dac_step = dac_tick_i & (~dac_cfg_r[CFG_HALF] | dac_ph_r);
  assign adc_step = adc_tick_i & (~adc_cfg_r[CFG_HALF] | adc_ph_r);

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      dac_ph_r <= 1'b0;
      adc_ph_r <= 1'b0;
    end else begin
      dac_ph_r <= dac_tick_i ? ~dac_ph_r : dac_ph_r;
      adc_ph_r <= adc_tick_i ? ~adc_ph_r : adc_ph_r;
    end
  end

  // effective targets: sequencer forces mute while switching or powering
  logic force_mute;
  logic [7:0] tgt [2];
  logic all_muted;
  logic all_eq;
  assign force_mute = (state_r != ST_RUN);

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      // count is the low 7 bits, 0 to 127 steps; mute overrides
      tgt[c] = (force_mute | vol_r[c][VOL_MUTE]) ? GAIN_MUTE : {1'b0, vol_r[c][6:0]};
    end
  end

  // exit conditions for the sequencer and the done flag
  assign all_muted = (app_r[0] == GAIN_MUTE) & (app_r[1] == GAIN_MUTE);
  assign all_eq = (app_r[0] == tgt[0]) & (app_r[1] == tgt[1]);

  // applied gain per channel
  generate
    for (genvar c = 0; c < 2; c++) begin : g_dac
      always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
          app_r[c] <= GAIN_MUTE;
        end else if (state_r == ST_OFF) begin
          app_r[c] <= GAIN_MUTE;
        end else if (dac_cfg_r[CFG_SS_OFF]) begin
          app_r[c] <= tgt[c];
        end else if (dac_step) begin
          app_r[c] <= step8(app_r[c], tgt[c]);
        end
      end
      // the mute code decodes to mute with a zero count
      assign dac_gain_o[c].mute = (app_r[c] == GAIN_MUTE);
      assign dac_gain_o[c].atten = app_r[c][6:0];
    end
  endgenerate

  // completion flag; a fresh volume write always clears it
  // a flag left high across a write would let the host trust a stale ramp
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      done_r <= 1'b1;
    end else if (vol_wr) begin
      done_r <= 1'b0;
    end else begin
      done_r <= all_eq & ~force_mute;
    end
  end

  // power and effects sequencer
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_r <= ST_OFF;
    end else begin
      case (state_r)
        ST_OFF: begin
          if (pwr_r[PWR_DAC]) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          // power-down outranks an effects change
          if (~pwr_r[PWR_DAC]) begin
            state_r <= ST_DOWN;
          end else if (dac_cfg_r[CFG_FX:CFG_DEEMPH] != fx_app_r) begin
            state_r <= ST_FX_MUTE;
          end
        end
        ST_FX_MUTE: begin
          // mode is swapped only once both channels sit at mute
          if (all_muted) begin
            state_r <= pwr_r[PWR_DAC] ? ST_RUN : ST_DOWN;
          end
        end
        ST_DOWN: begin
          // power goes only once both channels sit at mute
          if (all_muted) begin
            state_r <= ST_OFF;
          end
        end
        default: state_r <= ST_OFF;
      endcase
    end
  end

  // effects mode changes only while muted
  // trade-off: an effects change while running costs a full ramp down and back up
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      fx_app_r <= 2'b00;
    end else if (state_r == ST_FX_MUTE && all_muted) begin
      fx_app_r <= dac_cfg_r[CFG_FX:CFG_DEEMPH];
    end else if (state_r == ST_OFF) begin
      // no audio flows, so the mode may follow at once
      fx_app_r <= dac_cfg_r[CFG_FX:CFG_DEEMPH];
    end
  end

  assign deemph_on_o = fx_app_r[0];
  assign fx_on_o = fx_app_r[1];
  assign dac_pwr_o = (state_r != ST_OFF);

  // input level soft-step, one unit per capture step
  generate
    for (genvar i = 0; i < NUM_IN; i++) begin : g_in
      logic [3:0] in_app_r;
      logic [3:0] in_tgt;
      // limit request to -12 dB
      // a request above the range is clamped, never refused
      assign in_tgt = (in_req_r[4*i +: 4] > IN_LVL_MAX) ? IN_LVL_MAX : in_req_r[4*i +: 4];
      always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
          in_app_r <= 4'h0;
        end else if (adc_cfg_r[CFG_SS_OFF]) begin
          in_app_r <= in_tgt;
        end else if (adc_step && in_app_r < in_tgt) begin
          in_app_r <= in_app_r + 4'd1;
        end else if (adc_step && in_app_r > in_tgt) begin
          in_app_r <= in_app_r - 4'd1;
        end
      end
      assign in_lvl_o[4*i +: 4] = in_app_r;
    end
  endgenerate

  // output driver levels, clamped at +9 dB
  // registered so the driver pins never see the compare settle
  generate
    for (genvar d = 0; d < 2; d++) begin : g_out
      logic [3:0] lvl_r; // level handed to driver d
      always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
          lvl_r <= 4'h0;
        end else if (out_lvl_r[4*d +: 4] > OUT_LVL_MAX) begin
          lvl_r <= OUT_LVL_MAX;
        end else begin
          lvl_r <= out_lvl_r[4*d +: 4];
        end
      end
      assign out_lvl_o[4*d +: 4] = lvl_r;
    end
  endgenerate

  // line drivers: enable low means pins float
  assign line_oe_o = {pwr_r[PWR_LINE_R], pwr_r[PWR_LINE_L]};

  // capture amp source switches; several on means a mix
  assign mix_l_o = route_r[4:0];
  assign mix_r_o = route_r[9:5];

  // analog settings
  assign ana_o.bias = bias_r;
  assign ana_o.cm = cm_r;
  // channel analog power also needs the dac itself up
  assign ana_o.ana_pwr = {pwr_r[PWR_ANA_R], pwr_r[PWR_ANA_L]} & {2{dac_pwr_o}};
  assign ana_o.dac_mixer_route = route_r[ROUTE_MIX];
  assign ana_o.dac_direct_line_route = route_r[ROUTE_DIRECT];

endmodule : dvsc_top
`default_nettype wire

/* dvsc_checker.sv */
// dvsc_checker: port assertions of the volume control
`timescale 1ns/1ps
`default_nettype none
module dvsc_checker
  import dvsc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // dac side
  input wire dvsc_gain_type [1:0] dac_gain_o,
  input wire logic dac_pwr_o,
  input wire logic [7:0] out_lvl_o,
  input wire dvsc_ana_type ana_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);
  // answer is a pulse in the second access cycle
  a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("pready too long");
  a_ready_wait: assert property (pready_o |-> penable_i && $past(psel_i && penable_i)) else $error("pready early");
  a_err_ready: assert property (pslverr_o |-> pready_o) else $error("pslverr alone");
  a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0000_0000) else $error("stray prdata");
  // muted code carries no attenuation count
  a_mute_code: assert property (
    dac_gain_o[0].mute |-> dac_gain_o[0].atten == 7'h00) else $error("mute code wrong");
  // off means muted and unpowered
  a_off_muted: assert property (
    !dac_pwr_o |-> dac_gain_o == {GAIN_MUTE, GAIN_MUTE}) else $error("gain live while off");
  a_off_unpowered: assert property (
    !dac_pwr_o |-> ana_o.ana_pwr == 2'b00) else $error("analog on while off");
  a_start_muted: assert property (
    $rose(dac_pwr_o) |-> dac_gain_o == {GAIN_MUTE, GAIN_MUTE}) else $error("power-up not muted");
  a_out_clamp: assert property (
    out_lvl_o[3:0] <= OUT_LVL_MAX && out_lvl_o[7:4] <= OUT_LVL_MAX) else $error("output level over max");
  // main scenarios reached
  c_err: cover property (pslverr_o);
  c_up: cover property ($rose(dac_pwr_o));
  c_down: cover property ($fell(dac_pwr_o));
endmodule : dvsc_checker
bind dvsc_top dvsc_checker u_chk (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .dac_gain_o(dac_gain_o),
  .dac_pwr_o(dac_pwr_o), .out_lvl_o(out_lvl_o), .ana_o(ana_o));
`default_nettype wire

/* dvsc_host.sv */
// dvsc_host: apb host model that programs the control registers
`timescale 1ns/1ps
`default_nettype none
module dvsc_host (
  // clock
  input wire logic clk_i,
  // requests
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [9:0] paddr_o,
  output logic [31:0] pwdata_o,
  // answer
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i
);
  // idle bus from time zero
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 10'h000;
    pwdata_o = 32'h0000_0000;
  end
  // one transfer; request held until pready is seen high or 16 cycles pass
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err, output logic hung);
    int n;
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= wr;
    paddr_o <= {idx, 2'b00};
    pwdata_o <= wd;
    @(posedge clk_i);
    penable_o <= 1'b1;
    hung = 1'b1;
    rd = 32'h0000_0000;
    err = 1'b0;
    // bounded wait, the bench judges a hang
    for (n = 0; n < 16 && hung; n++) begin
      @(posedge clk_i);
      if (pready_i === 1'b1) begin
        hung = 1'b0;
        rd = prdata_i;
        err = pslverr_i;
      end
    end
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // released lines must not keep old values
    paddr_o <= ~paddr_o;
    pwdata_o <= ~pwdata_o;
  endtask : xfer
endmodule : dvsc_host
`default_nettype wire

/* dac_volume_softstep_control_test.sv */
// dac_volume_softstep_control_test: directed bench of the volume control
`timescale 1ns/1ps
`default_nettype none
module dac_volume_softstep_control_test;
  import dvsc_pkg::*;
  // clock, reset, strobes
  logic ref_clk_i, srst_i, dac_tick_i, adc_tick_i;
  // apb wires
  logic psel, penable, pwrite, pready, pslverr, rerr;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  // design outputs
  dvsc_gain_type [1:0] gain;
  logic dac_pwr, deemph, fx_on;
  logic [23:0] in_lvl;
  logic [4:0] mix_l, mix_r;
  logic [7:0] out_lvl;
  logic [1:0] line_oe;
  dvsc_ana_type ana;
  // tallies
  int failures = 0;
  int samples_checked = 0;
  dvsc_top dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .dac_tick_i(dac_tick_i), .adc_tick_i(adc_tick_i), .dac_gain_o(gain), .dac_pwr_o(dac_pwr),
    .deemph_on_o(deemph), .fx_on_o(fx_on), .in_lvl_o(in_lvl), .mix_l_o(mix_l), .mix_r_o(mix_r),
    .out_lvl_o(out_lvl), .line_oe_o(line_oe), .ana_o(ana));
  dvsc_host host (.clk_i(ref_clk_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
    .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));
  // clock never stops, also past power-down
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  // one bus cycle; a hang ends the run
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
    logic h;
    host.xfer(w, idx, d, rdat, rerr, h);
    if (h !== 1'b0) begin
      failures++;
      $display("mismatch at %0t: no bus answer", $time);
      print_verdict();
    end
  endtask : bus
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : step
  // n one-cycle sample strobes with gaps
  task automatic tick(input bit adc, input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      if (adc) adc_tick_i <= 1'b1;
      else dac_tick_i <= 1'b1;
      @(posedge ref_clk_i);
      adc_tick_i <= 1'b0;
      dac_tick_i <= 1'b0;
    end
    step(1);
  endtask : tick
  task automatic t_reset();
    bus(0, IDX_STATUS, 0);
    chk(rdat & 32'hffff_fffe, 32'h0080_8002, "status");
    bus(0, IDX_BIAS, 0);
    chk(rdat, 0, "bias");
    bus(0, 8'h3f, 0);
    chk({rdat[30:0], rerr}, 1, "unmapped");
    $display("reset test done");
  endtask : t_reset
  task automatic t_up();
    bus(1, IDX_MASTER, 32'h7e);
    bus(1, IDX_PWR, 1);
    step(1);
    chk(gain, 16'h8080, "up muted");
    tick(0, 1);
    chk(gain, 16'h7f7f, "step one");
    tick(0, 1);
    chk(gain, 16'h7e7e, "step two");
    bus(0, IDX_STATUS, 0);
    chk(rdat, 32'h007e_7e01, "done");
    bus(1, IDX_DAC_CFG, 32'h2);
    bus(1, IDX_MASTER, 32'h7c);
    bus(0, IDX_STATUS, 0);
    chk(rdat[0], 0, "done cleared");
    tick(0, 2);
    chk(gain, 16'h7d7d, "half rate");
    tick(0, 2);
    chk(gain, 16'h7c7c, "half rate end");
    $display("soft-step test done");
  endtask : t_up
  task automatic t_noss();
    bus(1, IDX_DAC_CFG, 32'h1);
    bus(1, IDX_MASTER, 32'h10);
    step(2);
    chk(gain, 16'h1010, "no ramp");
    bus(1, IDX_VOL_L, 32'h90);
    bus(1, IDX_VOL_R, 32'h7f);
    step(2);
    chk(gain, 16'h7f80, "mute left");
    bus(1, IDX_MASTER, 32'h7e);
    bus(1, IDX_DAC_CFG, 32'hc);
    step(1);
    chk(fx_on, 0, "fx early");
    tick(0, 2);
    step(3);
    chk({gain, deemph, fx_on}, 18'h2_0203, "fx swap");
    tick(0, 2);
    chk(gain, 16'h7e7e, "fx unmute");
    $display("effects test done");
  endtask : t_noss
  task automatic t_down();
    bus(1, IDX_PWR, 0);
    step(1);
    bus(0, IDX_STATUS, 0);
    chk({rdat, dac_pwr}, 33'h0_00fc_fc01, "ramping down");
    tick(0, 2);
    step(3);
    chk(dac_pwr, 0, "powered off");
    bus(0, IDX_STATUS, 0);
    chk(rdat[1], 1, "pd flag");
    $display("power-down test done");
  endtask : t_down
  task automatic t_misc();
    bus(1, IDX_ADC_CFG, 1);
    bus(1, IDX_IN_LVL, 32'hf3);
    step(2);
    chk(in_lvl, 24'h83, "in level clamp");
    bus(1, IDX_ADC_CFG, 0);
    bus(1, IDX_IN_LVL, 32'h5);
    tick(1, 2);
    chk(in_lvl, 24'h65, "in level ramp");
    bus(1, IDX_ADC_CFG, 2);
    bus(1, IDX_IN_LVL, 32'h7);
    tick(1, 2);
    chk(in_lvl, 24'h56, "in level half rate");
    bus(1, IDX_BIAS, 32'hc0);
    bus(1, IDX_CM, 3);
    bus(1, IDX_OUT_LVL, 32'hf5);
    bus(1, IDX_ROUTE, 32'hfff);
    bus(1, IDX_PWR, 32'h18);
    step(2);
    chk({ana, out_lvl, mix_l, mix_r, line_oe}, 32'h0f39_5fff, "analog set");
    bus(1, IDX_PWR, 32'h0b);
    step(2);
    chk({ana.ana_pwr, line_oe}, 4'h5, "left only");
    bus(0, IDX_BIAS, 0);
    chk(rdat, 32'hc0, "bias back");
    $display("settings test done");
  endtask : t_misc
  initial begin
    srst_i = 1'b1;
    dac_tick_i = 1'b0;
    adc_tick_i = 1'b0;
    repeat (8) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_up();
    t_noss();
    t_down();
    t_misc();
    print_verdict();
  end
endmodule : dac_volume_softstep_control_test
`default_nettype wire
